// ===== cdr_control_status_regs.sv
// Control and status register bank of the clock and data recovery
// receiver, reached from a host over the two-wire serial port.
// Assumes scl and sda are open-drain pins resolved outside this module
// and that the core status lines are asynchronous levels.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Sample phase code limited to -30..+30
// - One phase step is 1/60 UI
// - Status bit 5 shows signal loss
// - Status bit 4 sticky lock-loss flag
// - Status bit 2 set when rate measured
// - Control A bit 0 selects lock source
// - Control B bit 7 configures lock-loss pin
// - Control B bit 6 pulse clears sticky
// - Control B bit 3 pulse clears done
// - Control C bit 1 selects squelch mode
// - Error status bit 0 marks measurement end
module cdr_control_status_regs #(
  parameter logic [6:0] DEV_ADDR = cdr_regs_pkg::SERIAL_ADDR_DEFAULT,
  parameter int         TALLY_W  = 40
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  // Serial port pins
  input  wire logic                     sclIn,
  input  wire logic                     sdaIn,
  output logic                          sdaOut,
  output logic                          sdaOe,
  // Recovery core status
  input  wire cdr_regs_pkg::coreStatus_s coreStatus,
  input  wire logic [TALLY_W-1:0]       errTally,
  input  wire logic [5:0]               errConverterCode,
  // Recovery core controls
  output cdr_regs_pkg::coreCtrl_s       coreCtrl,
  output logic                          lockLossPin
);
  import cdr_regs_pkg::*;

  localparam int TALLY_BYTES = TALLY_W / 8;

  function automatic logic [5:0] clampPhase(input logic [5:0] code);
    logic signed [5:0] s;
    s = signed'(code);
    if (s < PHASE_MIN) clampPhase = PHASE_MIN;
    else if (s > PHASE_MAX) clampPhase = PHASE_MAX;
    else clampPhase = code;
  endfunction

  // Synchronisers: the first stage feeds only the second.
  logic        sclMeta, sclSync, sclPrev;
  logic        sdaMeta, sdaSync, sdaPrev;
  coreStatus_s stMeta, stSync, stPrev;
  logic [TALLY_W-1:0] tallyMeta, tallySync;
  logic [5:0]  convMeta, convSync;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  // The tally and converter code are quasi-static while being read.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stMeta    <= '0;
      stSync    <= '0;
      stPrev    <= '0;
      tallyMeta <= '0;
      tallySync <= '0;
      convMeta  <= '0;
      convSync  <= '0;
    end else begin
      stMeta    <= coreStatus;
      stSync    <= stMeta;
      stPrev    <= stSync;
      tallyMeta <= errTally;
      tallySync <= tallyMeta;
      convMeta  <= errConverterCode;
      convSync  <= convMeta;
    end
  end

  logic sclRise, sclFall, startCond, stopCond;
  assign sclRise   = sclSync && !sclPrev;
  assign sclFall   = !sclSync && sclPrev;
  assign startCond = sclSync && sclPrev && sdaPrev && !sdaSync;
  assign stopCond  = sclSync && sclPrev && !sdaPrev && sdaSync;

  // Register state.
  logic [7:0] lockSrcReg, lockLossReg, squelchReg, errCtrlReg;
  logic [7:0] upperReg, lowerReg, limitLsbReg, phaseReg;
  logic       lockStickyReg, rateDoneReg, errDoneReg;
  logic       wrEnReg;
  logic [7:0] wrAddrReg, wrDataReg;

  // Serial engine state.
  serState_e  state;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg, txReg, ptrReg;
  logic       isAddr, readMode, havePtr, masterAck;
  logic [7:0] readData, statusByte, tallyByte;

  always_comb begin
    statusByte = REG_RESET;
    statusByte[ST_SIG_LOST]  = stSync.signalLost;
    statusByte[ST_STICKY]    = lockStickyReg;
    statusByte[ST_ACQUIRING] = stSync.acquiring;
    statusByte[ST_MEAS_DONE] = rateDoneReg;
  end

  always_comb begin
    tallyByte = UNMAPPED_READ;
    for (int i = 0; i < TALLY_BYTES; i++) begin
      if (errCtrlReg[BYTE_SEL_HI:0] == 3'(i)) tallyByte = tallySync[i*8 +: 8];
    end
  end

  always_comb begin
    readData = UNMAPPED_READ;
    unique case (ptrReg)
      OFF_STATUS:       readData = statusByte;
      OFF_LOCK_SRC_RB:  readData = lockSrcReg;
      OFF_LOCK_LOSS_RB: readData = lockLossReg;
      OFF_ERR_STATUS:   readData = {7'h00, errDoneReg};
      OFF_ERR_BYTE:     readData = tallyByte;
      OFF_ERR_CONV:     readData = {2'h0, convSync};
      default:          readData = UNMAPPED_READ;
    endcase
  end

  // Serial slave: shift on scl rise, drive sda after scl fall.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state     <= SER_IDLE;
      bitCnt    <= 4'h0;
      shiftReg  <= 8'h00;
      txReg     <= 8'h00;
      ptrReg    <= 8'h00;
      isAddr    <= 1'b0;
      readMode  <= 1'b0;
      havePtr   <= 1'b0;
      masterAck <= 1'b0;
      sdaOe     <= 1'b0;
      wrEnReg   <= 1'b0;
      wrAddrReg <= 8'h00;
      wrDataReg <= 8'h00;
    end else begin
      wrEnReg <= 1'b0;
      if (startCond) begin
        state  <= SER_RX;
        bitCnt <= 4'h0;
        isAddr <= 1'b1;
        sdaOe  <= 1'b0;
      end else if (stopCond) begin
        state <= SER_IDLE;
        sdaOe <= 1'b0;
      end else begin
        unique case (state)
          SER_IDLE: begin
          end
          SER_RX: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sdaSync};
              bitCnt   <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
              bitCnt <= 4'h0;
              if (isAddr) begin
                if (shiftReg[7:1] == DEV_ADDR) begin
                  readMode <= shiftReg[0];
                  havePtr  <= shiftReg[0] && havePtr;
                  sdaOe    <= 1'b1;
                  state    <= SER_ACK;
                end else begin
                  state <= SER_IDLE;
                end
              end else if (!havePtr) begin
                ptrReg  <= shiftReg;
                havePtr <= 1'b1;
                sdaOe   <= 1'b1;
                state   <= SER_ACK;
              end else begin
                wrEnReg   <= 1'b1;
                wrAddrReg <= ptrReg;
                wrDataReg <= shiftReg;
                ptrReg    <= ptrReg + 8'h01;
                sdaOe     <= 1'b1;
                state     <= SER_ACK;
              end
            end
          end
          SER_ACK: begin
            if (sclFall) begin
              isAddr <= 1'b0;
              if (readMode) begin
                txReg  <= readData;
                ptrReg <= ptrReg + 8'h01;
                sdaOe  <= !readData[7];
                bitCnt <= FIRST_TX_BIT;
                state  <= SER_TX;
              end else begin
                sdaOe <= 1'b0;
                state <= SER_RX;
              end
            end
          end
          SER_TX: begin
            if (sclFall) begin
              if (bitCnt == BITS_PER_BYTE) begin
                sdaOe <= 1'b0;
                state <= SER_TXACK;
              end else begin
                txReg  <= {txReg[6:0], 1'b0};
                sdaOe  <= !txReg[6];
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          SER_TXACK: begin
            if (sclRise) begin
              masterAck <= !sdaSync;
            end else if (sclFall) begin
              if (masterAck) begin
                txReg  <= readData;
                ptrReg <= ptrReg + 8'h01;
                sdaOe  <= !readData[7];
                bitCnt <= FIRST_TX_BIT;
                state  <= SER_TX;
              end else begin
                state <= SER_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Open drain: the pin is only ever pulled low.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) sdaOut <= 1'b0;
    else sdaOut <= 1'b0;
  end

  // Write decode and one-shot events.
  logic wrLockSrc, wrLockLoss, wrErrCtrl;
  logic measReq, clrLock, clrMeas, freqAcq, errStart;
  logic lockEvent, rateEvent, errEvent;
  assign wrLockSrc  = wrEnReg && wrAddrReg == OFF_LOCK_SRC;
  assign wrLockLoss = wrEnReg && wrAddrReg == OFF_LOCK_LOSS;
  assign wrErrCtrl  = wrEnReg && wrAddrReg == OFF_ERR_CTRL_A;
  assign measReq    = wrLockSrc && wrDataReg[BIT_MEASURE];
  assign clrLock    = wrLockLoss && lockLossReg[BIT_CLR_LOCK]
                      && !wrDataReg[BIT_CLR_LOCK];
  assign clrMeas    = wrLockLoss && lockLossReg[BIT_CLR_MEAS]
                      && !wrDataReg[BIT_CLR_MEAS];
  assign freqAcq    = wrLockLoss && lockLossReg[BIT_FREQ_ACQ]
                      && !wrDataReg[BIT_FREQ_ACQ];
  assign errStart   = wrErrCtrl && errCtrlReg[BIT_ERR_START]
                      && !wrDataReg[BIT_ERR_START];
  assign lockEvent  = stSync.lockLost && !stPrev.lockLost;
  assign rateEvent  = stSync.rateDone && !stPrev.rateDone;
  assign errEvent   = stSync.errDone && !stPrev.errDone;

  // Unused bits are stored as written, except phase bits 7:6, which are stored as zero; the host keeps them zero.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lockSrcReg  <= REG_RESET;
      lockLossReg <= REG_RESET;
      squelchReg  <= REG_RESET;
      errCtrlReg  <= REG_RESET;
      upperReg    <= REG_RESET;
      lowerReg    <= REG_RESET;
      limitLsbReg <= REG_RESET;
      phaseReg    <= REG_RESET;
    end else if (wrEnReg) begin
      unique case (wrAddrReg)
        OFF_LOCK_SRC:    lockSrcReg  <= wrDataReg;
        OFF_LOCK_LOSS:   lockLossReg <= wrDataReg;
        OFF_SQUELCH:     squelchReg  <= wrDataReg;
        OFF_ERR_CTRL_A:  errCtrlReg  <= wrDataReg;
        OFF_UPPER_LIMIT: upperReg    <= wrDataReg;
        OFF_LOWER_LIMIT: lowerReg    <= wrDataReg;
        OFF_LIMIT_LSB:   limitLsbReg <= wrDataReg;
        OFF_PHASE:       phaseReg    <= {2'h0, clampPhase(wrDataReg[5:0])};
        default: begin
        end
      endcase
    end
  end

  // Sticky flags: a hardware event in the clearing cycle wins.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lockStickyReg <= 1'b0;
      rateDoneReg   <= 1'b0;
      errDoneReg    <= 1'b0;
    end else begin
      if (lockEvent) lockStickyReg <= 1'b1;
      else if (clrLock) lockStickyReg <= 1'b0;
      if (rateEvent) rateDoneReg <= 1'b1;
      else if (clrMeas || measReq) rateDoneReg <= 1'b0;
      if (errEvent) errDoneReg <= 1'b1;
      else if (errStart) errDoneReg <= 1'b0;
    end
  end

  // Core controls and the lock-loss pin, all registered.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      coreCtrl    <= '0;
      lockLossPin <= 1'b0;
    end else begin
      coreCtrl.lockToRef        <= lockSrcReg[BIT_LOCK_REF];
      coreCtrl.measureStart     <= measReq;
      coreCtrl.freqAcqStart     <= freqAcq;
      coreCtrl.squelchEither    <= squelchReg[BIT_SQUELCH];
      coreCtrl.sigLossActiveLow <= squelchReg[BIT_SIG_POL];
      coreCtrl.phaseCode        <= phaseReg[5:0];
      coreCtrl.errWindowSel     <= errCtrlReg[WINDOW_HI:WINDOW_LO];
      coreCtrl.errStart         <= errStart;
      coreCtrl.upperRateLimit   <= {upperReg, limitLsbReg[LIMIT_LSB_UPPER]};
      coreCtrl.lowerRateLimit   <= {lowerReg, limitLsbReg[LIMIT_LSB_LOWER]};
      lockLossPin <= lockLossReg[BIT_PIN_CFG] ? lockStickyReg
                                              : stSync.lockLost;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence phaseWrite;
    wrEnReg && wrAddrReg == OFF_PHASE;
  endsequence
  sequence clearLockPulse;
    clrLock && !lockEvent;
  endsequence

  phase_range_a: assert property (
    signed'(phaseReg[5:0]) >= PHASE_MIN && signed'(phaseReg[5:0]) <= PHASE_MAX)
    else $error("phase code outside legal span");
  phase_code_out_a: assert property (
    phaseWrite ##1 1'b1 |=> coreCtrl.phaseCode == $past(phaseReg, 1))
    else $error("phase code not forwarded");
  conv_readback_a: assert property (
    ptrReg == OFF_ERR_CONV |-> readData == {2'h0, convSync})
    else $error("converter readback wrong");
  sig_loss_bit_a: assert property (
    statusByte[ST_SIG_LOST] == stSync.signalLost)
    else $error("signal loss bit wrong");
  lock_sticky_a: assert property (
    lockEvent |=> lockStickyReg [*2] or (lockStickyReg ##1 clrLock))
    else $error("sticky lock loss not held");
  meas_done_a: assert property (
    rateEvent |=> statusByte[ST_MEAS_DONE])
    else $error("measurement complete not set");
  measure_req_a: assert property (
    measReq |=> coreCtrl.measureStart ##1 !coreCtrl.measureStart || measReq)
    else $error("measure request pulse wrong");
  lock_src_a: assert property (
    wrLockSrc |=> ##1 coreCtrl.lockToRef == $past(wrDataReg[BIT_LOCK_REF], 2))
    else $error("lock source not applied");
  pin_follow_a: assert property (
    ##1 lockLossPin == ($past(lockLossReg[BIT_PIN_CFG])
      ? $past(lockStickyReg) : $past(stSync.lockLost)))
    else $error("lock loss pin wrong");
  sticky_clear_a: assert property (
    clearLockPulse |=> !lockStickyReg)
    else $error("sticky flag not cleared");
  done_clear_a: assert property (
    clrMeas && !rateEvent |=> !rateDoneReg)
    else $error("measurement complete not cleared");
  squelch_mode_a: assert property (
    ##2 coreCtrl.squelchEither == $past(squelchReg[BIT_SQUELCH]))
    else $error("squelch mode wrong");
  err_done_a: assert property (
    errEvent |=> errDoneReg && ptrReg != OFF_ERR_STATUS || readData[ST_ERR_DONE])
    else $error("measurement end not flagged");
  acquiring_bit_a: assert property (
    statusByte[ST_ACQUIRING] == stSync.acquiring)
    else $error("acquiring bit wrong");

endmodule // cdr_control_status_regs
`default_nettype wire

// ===== cdr_regs_pkg.sv
// Constants, types and register map of the receiver control/status bank.
// Assumes one system clock; the core status lines come from another domain.
package cdr_regs_pkg;

  // Two-wire serial port.
  localparam logic [6:0] SERIAL_ADDR_DEFAULT = 7'h40; // Arbitrary value.
  localparam logic [3:0] BITS_PER_BYTE       = 4'h8;
  localparam logic [3:0] FIRST_TX_BIT        = 4'h1;

  // Register offsets.
  localparam logic [7:0] OFF_STATUS        = 8'h04;
  localparam logic [7:0] OFF_LOCK_SRC_RB   = 8'h05;
  localparam logic [7:0] OFF_LOCK_LOSS_RB  = 8'h06;
  localparam logic [7:0] OFF_LOCK_SRC      = 8'h08;
  localparam logic [7:0] OFF_LOCK_LOSS     = 8'h09;
  localparam logic [7:0] OFF_SQUELCH       = 8'h11;
  localparam logic [7:0] OFF_ERR_CTRL_A    = 8'h1E;
  localparam logic [7:0] OFF_ERR_STATUS    = 8'h20;
  localparam logic [7:0] OFF_ERR_BYTE      = 8'h21;
  localparam logic [7:0] OFF_ERR_CONV      = 8'h24;
  localparam logic [7:0] OFF_UPPER_LIMIT   = 8'h35;
  localparam logic [7:0] OFF_LOWER_LIMIT   = 8'h36;
  localparam logic [7:0] OFF_PHASE         = 8'h37;
  localparam logic [7:0] OFF_LIMIT_LSB     = 8'h39;

  localparam logic [7:0] REG_RESET         = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // Field positions.
  localparam int BIT_LOCK_REF    = 0;
  localparam int BIT_MEASURE     = 1;
  localparam int BIT_CLR_MEAS    = 3;
  localparam int BIT_FREQ_ACQ    = 5;
  localparam int BIT_CLR_LOCK    = 6;
  localparam int BIT_PIN_CFG     = 7;
  localparam int BIT_SQUELCH     = 1;
  localparam int BIT_SIG_POL     = 2;
  localparam int BIT_ERR_START   = 3;
  localparam int ST_SIG_LOST     = 5;
  localparam int ST_STICKY       = 4;
  localparam int ST_ACQUIRING    = 3;
  localparam int ST_MEAS_DONE    = 2;
  localparam int ST_ERR_DONE     = 0;
  localparam int LIMIT_LSB_UPPER = 1;
  localparam int LIMIT_LSB_LOWER = 0;
  localparam int BYTE_SEL_HI     = 2;
  localparam int WINDOW_LO       = 5;
  localparam int WINDOW_HI       = 7;
  localparam int PHASE_W         = 6;

  // Sample phase: one code step is 1/60 UI.
  localparam int PHASE_STEPS_PER_UI = 60;
  localparam logic signed [5:0] PHASE_MIN = -6'sd30;
  localparam logic signed [5:0] PHASE_MAX = 6'sd30;

  typedef enum logic [2:0] {
    SER_IDLE, SER_RX, SER_ACK, SER_TX, SER_TXACK
  } serState_e;

  // Level status lines from the recovery core.
  typedef struct packed {
    logic signalLost;
    logic lockLost;
    logic acquiring;
    logic rateDone;
    logic errDone;
  } coreStatus_s;

  // Controls to the recovery core.
  typedef struct packed {
    logic       lockToRef;
    logic       measureStart;
    logic       freqAcqStart;
    logic       squelchEither;
    logic       sigLossActiveLow;
    logic [5:0] phaseCode;
    logic [2:0] errWindowSel;
    logic       errStart;
    logic [8:0] upperRateLimit;
    logic [8:0] lowerRateLimit;
  } coreCtrl_s;

endpackage

// ===== cdr_i2c_host.sv
// Two-wire host model that configures and polls the register bank.
// Assumes the bench resolves the open-drain sda wire; no clock stretching.
`timescale 1ns/1ps
`default_nettype none
module cdr_i2c_host #(
  parameter logic [6:0] ADDR = cdr_regs_pkg::SERIAL_ADDR_DEFAULT,
  parameter int         HALF = 6
) (
  // Clock and pins
  input  wire logic clk_sys,
  input  wire logic sdaWire,
  output var  logic sclLine,
  output var  logic sdaLow
);
  initial begin
    sclLine = 1'b1;
    sdaLow  = 1'b0;
  end

  task automatic wt();
    repeat (HALF) @(negedge clk_sys);
  endtask

  // Data moves only while scl is low, so no false start or stop appears.
  task automatic bit_io(input logic b, output logic r);
    sdaLow = !b;
    wt();
    sclLine = 1'b1;
    wt();
    r = sdaWire;
    sclLine = 1'b0;
    wt();
  endtask

  task automatic start();
    sdaLow = 1'b0;
    wt();
    sclLine = 1'b1;
    wt();
    sdaLow = 1'b1;
    wt();
    sclLine = 1'b0;
    wt();
  endtask

  task automatic stop();
    sdaLow = 1'b1;
    wt();
    sclLine = 1'b1;
    wt();
    sdaLow = 1'b0;
    wt();
  endtask

  task automatic xfer(input logic [7:0] tx, input logic rel,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(rel, r);
    ack = !r;
  endtask

  task automatic write_reg(input logic [7:0] off, d, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer({ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(off, 1'b1, rx, a1);
    xfer(d, 1'b1, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // A single-byte read ends with a refusal so the device lets go of sda.
  task automatic read_reg(input logic [7:0] off, output logic [7:0] d,
                          output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start();
    xfer({ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(off, 1'b1, rx, a1);
    start();
    xfer({ADDR, 1'b1}, 1'b1, rx, a2);
    xfer(8'hFF, 1'b1, d, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // Clear requests are a one followed by a zero in the same bit.
  task automatic pulse(input logic [7:0] off, base, mask, output logic ok);
    logic a;
    write_reg(off, base | mask, a);
    write_reg(off, base, ok);
  endtask
endmodule // cdr_i2c_host
`default_nettype wire

// ===== test_cdr_control_status_regs.sv
// Self-checking bench for the receiver control and status bank.
// Assumes the host model above and a free-running 25 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module test_cdr_control_status_regs;
  import cdr_regs_pkg::*;
  logic        clk_sys          = 1'b0;
  logic        nrst             = 1'b0;
  logic        sclLine;
  logic        sdaLow;
  logic        sdaOut;
  logic        sdaOe;
  logic        sdaWire;
  logic        lockLossPin;
  logic        ok;
  logic [7:0]  rd;
  logic [39:0] errTally         = '0;
  logic [5:0]  errConverterCode = '0;
  coreStatus_s coreStatus       = '0;
  coreCtrl_s   coreCtrl;
  integer      seed             = 32'h01a220be;
  int          error_cnt        = 0;
  int          samples_checked  = 0;
  int          cycles           = 0;
  int          measCnt          = 0;

  always #20 clk_sys = ~clk_sys;
  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & !sdaLow;

  cdr_control_status_regs i_cdr_control_status_regs (
    .clk_sys(clk_sys), .nrst(nrst), .sclIn(sclLine), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .coreStatus(coreStatus),
    .errTally(errTally), .errConverterCode(errConverterCode),
    .coreCtrl(coreCtrl), .lockLossPin(lockLossPin));

  cdr_i2c_host i_cdr_i2c_host (
    .clk_sys(clk_sys), .sdaWire(sdaWire), .sclLine(sclLine),
    .sdaLow(sdaLow));

  always @(posedge clk_sys) begin
    if (coreCtrl.measureStart === 1'b1) begin
      measCnt <= measCnt + 1;
    end
  end

  // The run needs about 23000 cycles; the ceiling leaves ample margin.
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic settle();
    repeat (6) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] off, d);
    i_cdr_i2c_host.write_reg(off, d, ok);
    settle();
  endtask

  task automatic rdc(input logic [7:0] off);
    i_cdr_i2c_host.read_reg(off, rd, ok);
  endtask

  function automatic logic [7:0] stat(input logic sticky, meas);
    stat = {2'b00, coreStatus.signalLost, sticky, coreStatus.acquiring,
            meas, 2'b00};
  endfunction

  function automatic logic [5:0] clampPh(input logic signed [5:0] v);
    if (v > PHASE_MAX) begin
      clampPh = PHASE_MAX;
    end else if (v < PHASE_MIN) begin
      clampPh = PHASE_MIN;
    end else begin
      clampPh = v;
    end
  endfunction

  initial begin : main
    logic [5:0] ph;
    logic [5:0] tbl [5];
    int m;
    tbl = '{6'h00, 6'h1E, 6'h22, 6'h1F, 6'h20};
    repeat (20) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    rdc(OFF_STATUS);
    check(rd, 8'h00, "status after reset");
    for (int v = 1; v >= 0; v--) begin
      wr(OFF_LOCK_SRC, 8'(v));
      check({7'h0, coreCtrl.lockToRef}, 8'(v), "lock source");
    end
    $display("test lock_source finished");
    repeat (4) begin
      coreStatus.signalLost = 1'($random(seed));
      coreStatus.acquiring  = 1'($random(seed));
      settle();
      rdc(OFF_STATUS);
      check(rd, stat(1'b0, 1'b0), "level status");
    end
    $display("test level_status finished");
    coreStatus.lockLost = 1'b1;
    settle();
    check({7'h0, lockLossPin}, 8'h01, "pin normal high");
    coreStatus.lockLost = 1'b0;
    settle();
    check({7'h0, lockLossPin}, 8'h00, "pin normal low");
    rdc(OFF_STATUS);
    check(rd, stat(1'b1, 1'b0), "sticky held");
    wr(OFF_LOCK_LOSS, 8'h80);
    check({7'h0, lockLossPin}, 8'h01, "pin sticky");
    i_cdr_i2c_host.pulse(OFF_LOCK_LOSS, 8'h80, 8'h40, ok);
    settle();
    check({7'h0, lockLossPin}, 8'h00, "pin cleared");
    rdc(OFF_STATUS);
    check(rd, stat(1'b0, 1'b0), "sticky cleared");
    $display("test lock_loss finished");
    m = measCnt;
    wr(OFF_LOCK_SRC, 8'h02);
    check(8'(measCnt - m), 8'h01, "measure pulse");
    coreStatus.rateDone = 1'b1;
    settle();
    coreStatus.rateDone = 1'b0;
    rdc(OFF_STATUS);
    check(rd, stat(1'b0, 1'b1), "rate done");
    i_cdr_i2c_host.pulse(OFF_LOCK_LOSS, 8'h80, 8'h08, ok);
    rdc(OFF_STATUS);
    check(rd, stat(1'b0, 1'b0), "rate done cleared");
    $display("test rate_measure finished");
    for (int v = 2; v >= 0; v -= 2) begin
      wr(OFF_SQUELCH, 8'(v));
      check({7'h0, coreCtrl.squelchEither}, 8'(v / 2), "squelch");
    end
    $display("test squelch finished");
    // Out-of-span codes are corner cases; the rest stay inside the span.
    for (int i = 0; i < 9; i++) begin
      ph = (i < 5) ? tbl[i] : 6'($random(seed) % 31);
      wr(OFF_PHASE, {2'b00, ph});
      check({2'b00, coreCtrl.phaseCode}, {2'b00, clampPh(ph)}, "phase");
    end
    $display("test phase finished");
    errConverterCode = 6'($random(seed));
    coreStatus.errDone = 1'b1;
    settle();
    coreStatus.errDone = 1'b0;
    rdc(OFF_ERR_CONV);
    check({2'b00, rd[5:0]}, {2'b00, errConverterCode}, "converter");
    rdc(OFF_ERR_STATUS);
    check({7'h0, rd[0]}, 8'h01, "error done");
    i_cdr_i2c_host.pulse(OFF_ERR_CTRL_A, 8'h00, 8'h08, ok);
    rdc(OFF_ERR_STATUS);
    check({7'h0, rd[0]}, 8'h00, "error done restart");
    errTally = {$random(seed), 8'($random(seed))};
    wr(OFF_ERR_CTRL_A, 8'hA2);
    check({5'h0, coreCtrl.errWindowSel}, 8'h05, "window select");
    rdc(OFF_ERR_BYTE);
    check(rd, errTally[23:16], "tally byte");
    wr(OFF_SQUELCH, 8'h04);
    check({7'h0, coreCtrl.sigLossActiveLow}, 8'h01, "loss polarity");
    wr(OFF_UPPER_LIMIT, 8'hA5);
    wr(OFF_LOWER_LIMIT, 8'h3C);
    wr(OFF_LIMIT_LSB, 8'h02);
    check(coreCtrl.upperRateLimit[8:1], 8'hA5, "upper limit");
    check({7'h0, coreCtrl.upperRateLimit[0]}, 8'h01, "upper lsb");
    check(coreCtrl.lowerRateLimit[8:1], 8'h3C, "lower limit");
    check({7'h0, coreCtrl.lowerRateLimit[0]}, 8'h00, "lower lsb");
    $display("test error_monitor finished");
    print_verdict();
  end
endmodule // test_cdr_control_status_regs
`default_nettype wire
